// ===== usfdc_char_match.v
/*
 compares one received character with the programmed resume and pause
 characters under a two-bit pair selection.
 assumes inputs from logic on the same clock.
*/
`timescale 1ns/10ps

module usfdc_char_match #(
	parameter WIDTH = 8
) (
	input wire [WIDTH-1:0] charIn,
	input wire [1:0] pairSel,
	input wire anyResume,
	input wire [WIDTH-1:0] resumeFirst,
	input wire [WIDTH-1:0] resumeSecond,
	input wire [WIDTH-1:0] pauseFirst,
	input wire [WIDTH-1:0] pauseSecond,
	output wire isResume,
	output wire isPause,
	output wire isListed
);
	// ----------------------------------------
	// pair matching
	// ----------------------------------------
	wire useFirst;
	wire useSecond;
	wire listedResume;
	assign useFirst = pairSel[0];
	assign useSecond = pairSel[1];
	assign listedResume = (useFirst && charIn == resumeFirst) ||
		(useSecond && charIn == resumeSecond);
	assign isPause = (useFirst && charIn == pauseFirst) ||
		(useSecond && charIn == pauseSecond);
	assign isResume = (pairSel != 2'b00) && (anyResume || listedResume);
	assign isListed = isPause || listedResume;
endmodule // usfdc_char_match

// ===== usfdc_defines.vh
/*
 constants of the uart flow control and dma request gating block:
 register offsets, field positions and reset values.
 assumes a 32-bit register port with byte offsets.
*/
`ifndef USFDC_DEFINES_VH
`define USFDC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define USFDC_OFS_DMA_CTRL 8'h48
`define USFDC_OFS_FLOW_CFG 8'h50
`define USFDC_OFS_RESUME1 8'h54
`define USFDC_OFS_RESUME2 8'h58
`define USFDC_OFS_PAUSE1 8'h5c
`define USFDC_OFS_PAUSE2 8'h60
`define USFDC_OFS_STATUS 8'h64

// ----------------------------------------
// field positions
// ----------------------------------------
`define USFDC_DMA_RX_EN 0
`define USFDC_DMA_TX_EN 1
`define USFDC_DMA_STOP_ERR 3
`define USFDC_FC_EN 0
`define USFDC_FC_RXMODE_LO 1
`define USFDC_FC_TXMODE_LO 3
`define USFDC_FC_ANY 5
`define USFDC_FC_SPECIAL 6

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define USFDC_DMA_CTRL_W 4
`define USFDC_FLOW_CFG_W 7
`define USFDC_DMA_CTRL_RST 4'h0
`define USFDC_FLOW_CFG_RST 7'h00
`define USFDC_CHAR_RST 8'h00

`endif

// ===== usfdc_flow_ctrl.v
/*
 dma request gating and software flow control for a uart.
 assumes the uart core gives received characters as one-cycle strobes on
 this clock, raw dma requests and an error interrupt level on this clock.
 assumes the receive fifo almost-full level comes from this clock too,
 and that software writes reserved fields with their default values.
 holds no buffer: each received character is judged in the cycle it arrives.
*/
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "usfdc_defines.vh"

module usfdc_flow_ctrl #(
	parameter CHAR_W = 8
) (
	input wire clock,
	input wire rst,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdData,
	input wire rxDmaReqRaw,
	input wire txDmaReqRaw,
	input wire uartErrIrq,
	output wire rxDmaReq,
	output wire txDmaReq,
	input wire [CHAR_W-1:0] rxChar,
	input wire rxCharValid,
	output reg [CHAR_W-1:0] rxFifoData,
	output reg rxFifoWrite,
	output reg specialCharSeen,
	output wire txHalt,
	input wire rxFifoAlmostFull,
	output reg sendPauseReq,
	output reg sendResumeReq,
	output reg [CHAR_W-1:0] flowCharOut
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [`USFDC_DMA_CTRL_W-1:0] dmaCtrl_reg;
	reg [`USFDC_FLOW_CFG_W-1:0] flowCfg_reg;
	localparam N_CHARS = 4;
	// entry order: resume first, resume second, pause first, pause second
	localparam [8*N_CHARS-1:0] CHAR_ADDRS = {`USFDC_OFS_PAUSE2, `USFDC_OFS_PAUSE1,
		`USFDC_OFS_RESUME2, `USFDC_OFS_RESUME1};
	reg [CHAR_W-1:0] charTable_reg [0:N_CHARS-1];
	reg [31:0] rdData_next;
	wire [CHAR_W-1:0] resumeFirst;
	wire [CHAR_W-1:0] resumeSecond;
	wire [CHAR_W-1:0] pauseFirst;
	wire [CHAR_W-1:0] pauseSecond;
	wire txPaused;
	wire rxPaused;

	wire flowEn;
	wire [1:0] rxMode;
	wire [1:0] txMode;
	wire anyResume;
	wire specialEn;
	wire txFlowOn;
	wire rxFlowOn;

	// ----------------------------------------
	// configuration fields
	// ----------------------------------------
	assign flowEn = flowCfg_reg[`USFDC_FC_EN];
	assign rxMode = flowCfg_reg[`USFDC_FC_RXMODE_LO+1:`USFDC_FC_RXMODE_LO];
	assign txMode = flowCfg_reg[`USFDC_FC_TXMODE_LO+1:`USFDC_FC_TXMODE_LO];
	assign anyResume = flowCfg_reg[`USFDC_FC_ANY];
	assign specialEn = flowCfg_reg[`USFDC_FC_SPECIAL];
	assign txFlowOn = flowEn && (txMode != 2'b00);
	assign rxFlowOn = flowEn && (rxMode != 2'b00);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// reserved bits are not stored; software keeps them at default
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			dmaCtrl_reg <= `USFDC_DMA_CTRL_RST;
			flowCfg_reg <= `USFDC_FLOW_CFG_RST;
		end else if (regWrite) begin
			case (regAddr)
				`USFDC_OFS_DMA_CTRL: begin
					dmaCtrl_reg <= {regWrData[3], 1'b0, regWrData[1:0]};
				end
				`USFDC_OFS_FLOW_CFG: begin
					flowCfg_reg <= regWrData[`USFDC_FLOW_CFG_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// character registers, one per entry
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_CHARS; gi = gi + 1) begin : charEntry
			wire entryHit;
			assign entryHit = regWrite && (regAddr == CHAR_ADDRS[8*gi+:8]);
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					charTable_reg[gi] <= `USFDC_CHAR_RST;
				end else if (entryHit) begin
					charTable_reg[gi] <= regWrData[CHAR_W-1:0];
				end
			end
		end
	endgenerate

	assign resumeFirst = charTable_reg[0];
	assign resumeSecond = charTable_reg[1];
	assign pauseFirst = charTable_reg[2];
	assign pauseSecond = charTable_reg[3];

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always @* begin
		rdData_next = 32'h00000000;
		case (regAddr)
			`USFDC_OFS_DMA_CTRL: rdData_next[`USFDC_DMA_CTRL_W-1:0] = dmaCtrl_reg;
			`USFDC_OFS_FLOW_CFG: rdData_next[`USFDC_FLOW_CFG_W-1:0] = flowCfg_reg;
			`USFDC_OFS_RESUME1: rdData_next[CHAR_W-1:0] = resumeFirst;
			`USFDC_OFS_RESUME2: rdData_next[CHAR_W-1:0] = resumeSecond;
			`USFDC_OFS_PAUSE1: rdData_next[CHAR_W-1:0] = pauseFirst;
			`USFDC_OFS_PAUSE2: rdData_next[CHAR_W-1:0] = pauseSecond;
			`USFDC_OFS_STATUS: rdData_next[1:0] = {rxPaused, txPaused};
			default: rdData_next = 32'h00000000;
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdData <= 32'h00000000;
		end else if (regRead) begin
			regRdData <= rdData_next;
		end else begin
			regRdData <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// dma request gating
	// ----------------------------------------
	// gated requests follow the raw ones in the same cycle
	wire errorBlocksRx;
	wire rxDmaAllowed;
	wire txDmaAllowed;
	assign errorBlocksRx = dmaCtrl_reg[`USFDC_DMA_STOP_ERR] && uartErrIrq;
	assign rxDmaAllowed = dmaCtrl_reg[`USFDC_DMA_RX_EN] && !errorBlocksRx;
	assign txDmaAllowed = dmaCtrl_reg[`USFDC_DMA_TX_EN];
	assign rxDmaReq = rxDmaReqRaw && rxDmaAllowed;
	assign txDmaReq = txDmaReqRaw && txDmaAllowed;

	// ----------------------------------------
	// character matching
	// ----------------------------------------
	wire txResumeHit;
	wire txPauseHit;
	wire txListed;
	wire rxListed;

	usfdc_char_match #(
		.WIDTH(CHAR_W)
	) txMatch (
		.charIn(rxChar),
		.pairSel(txMode),
		.anyResume(anyResume),
		.resumeFirst(resumeFirst),
		.resumeSecond(resumeSecond),
		.pauseFirst(pauseFirst),
		.pauseSecond(pauseSecond),
		.isResume(txResumeHit),
		.isPause(txPauseHit),
		.isListed(txListed)
	);

	usfdc_char_match #(
		.WIDTH(CHAR_W)
	) rxMatch (
		.charIn(rxChar),
		.pairSel(rxMode),
		.anyResume(1'b0),
		.resumeFirst(resumeFirst),
		.resumeSecond(resumeSecond),
		.pauseFirst(pauseFirst),
		.pauseSecond(pauseSecond),
		.isResume(),
		.isPause(),
		.isListed(rxListed)
	);

	// ----------------------------------------
	// transmit pause state
	// ----------------------------------------
	// one-hot states
	localparam TX_RUN = 2'h1;
	localparam TX_HOLD = 2'h2;

	reg [1:0] txState_reg;
	reg [1:0] txState_next;

	// pause is checked first so a pause character never resumes itself
	always @* begin
		txState_next = txState_reg;
		case (txState_reg)
			TX_RUN: begin
				if (txFlowOn && rxCharValid && txPauseHit) begin
					txState_next = TX_HOLD;
				end
			end
			TX_HOLD: begin
				if (!txFlowOn) begin
					txState_next = TX_RUN;
				end else if (rxCharValid && txResumeHit && !txPauseHit) begin
					txState_next = TX_RUN;
				end
			end
			default: begin
				txState_next = TX_RUN;
			end
		endcase
	end

	// leaving flow control releases a held transmitter at once
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			txState_reg <= TX_RUN;
		end else begin
			txState_reg <= txState_next;
		end
	end

	assign txPaused = txState_reg[1];
	assign txHalt = txPaused;

	// ----------------------------------------
	// receive path filter
	// ----------------------------------------
	wire flowCharIn;
	wire fifoWrite_next;
	wire specialSeen_next;
	assign flowCharIn = txFlowOn && txListed;
	assign fifoWrite_next = rxCharValid && !flowCharIn;
	assign specialSeen_next = rxCharValid && specialEn && rxListed;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rxFifoData <= `USFDC_CHAR_RST;
			rxFifoWrite <= 1'b0;
			specialCharSeen <= 1'b0;
		end else begin
			rxFifoData <= rxChar;
			rxFifoWrite <= fifoWrite_next;
			specialCharSeen <= specialSeen_next;
		end
	end

	// ----------------------------------------
	// receive flow: ask peer to pause or resume
	// ----------------------------------------
	// one-hot states
	localparam RX_FLOWING = 2'h1;
	localparam RX_HELD = 2'h2;

	reg [1:0] rxState_reg;
	reg [1:0] rxState_next;
	reg sendPause_next;
	reg sendResume_next;
	reg [CHAR_W-1:0] flowChar_next;
	wire [CHAR_W-1:0] pauseSel;
	wire [CHAR_W-1:0] resumeSel;

	assign pauseSel = rxMode[0] ? pauseFirst : pauseSecond;
	assign resumeSel = rxMode[0] ? resumeFirst : resumeSecond;

	// a fifo that stays nearly full sends one pause only
	always @* begin
		rxState_next = rxState_reg;
		sendPause_next = 1'b0;
		sendResume_next = 1'b0;
		flowChar_next = flowCharOut;
		case (rxState_reg)
			RX_FLOWING: begin
				if (rxFlowOn && rxFifoAlmostFull) begin
					rxState_next = RX_HELD;
					sendPause_next = 1'b1;
					flowChar_next = pauseSel;
				end
			end
			RX_HELD: begin
				if (!rxFlowOn) begin
					rxState_next = RX_FLOWING;
				end else if (!rxFifoAlmostFull) begin
					rxState_next = RX_FLOWING;
					sendResume_next = 1'b1;
					flowChar_next = resumeSel;
				end
			end
			default: begin
				rxState_next = RX_FLOWING;
			end
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rxState_reg <= RX_FLOWING;
			sendPauseReq <= 1'b0;
			sendResumeReq <= 1'b0;
			flowCharOut <= `USFDC_CHAR_RST;
		end else begin
			rxState_reg <= rxState_next;
			sendPauseReq <= sendPause_next;
			sendResumeReq <= sendResume_next;
			flowCharOut <= flowChar_next;
		end
	end

	assign rxPaused = rxState_reg[1];
endmodule // usfdc_flow_ctrl

// ===== usfdc_flow_ctrl_asserts.sv
/*
 checker of the flow control block, bound to its top module.
 assumes the register port map and the one-cycle answers of the block.
*/
`timescale 1ns/10ps
module usfdc_flow_ctrl_asserts #(parameter CHAR_W = 8) (
	input clock, input rst, input [7:0] regAddr, input [31:0] regWrData,
	input regWrite, input regRead, input [31:0] regRdData,
	input rxDmaReqRaw, input txDmaReqRaw, input uartErrIrq, input rxDmaReq, input txDmaReq,
	input [CHAR_W-1:0] rxChar, input rxCharValid, input [CHAR_W-1:0] rxFifoData,
	input rxFifoWrite, input specialCharSeen, input txHalt, input rxFifoAlmostFull,
	input sendPauseReq, input sendResumeReq, input [CHAR_W-1:0] flowCharOut);
// ----------------------------------------
// shadow copies of the control registers
// ----------------------------------------
reg [3:0] dmaReg;
reg [6:0] cfgReg;
always @(posedge clock or posedge rst) begin
	if (rst) begin
		dmaReg <= 4'h0;
		cfgReg <= 7'h00;
	end else if (regWrite && regAddr == 8'h48) dmaReg <= regWrData[3:0];
	else if (regWrite && regAddr == 8'h50) cfgReg <= regWrData[6:0];
end
default clocking @(posedge clock); endclocking
default disable iff (rst);
sequence gotChar;
	rxCharValid ##1 rxFifoWrite;
endsequence
rx_dma_gate_a: assert property (rxDmaReq == (rxDmaReqRaw && dmaReg[0] && !(dmaReg[3] && uartErrIrq)))
	else $error("rx dma request gating wrong");
tx_dma_gate_a: assert property (txDmaReq == (txDmaReqRaw && dmaReg[1]))
	else $error("tx dma request gating wrong");
fifo_after_char_a: assert property (rxFifoWrite |-> $past(rxCharValid))
	else $error("fifo write without character");
fifo_data_copy_a: assert property (gotChar |-> rxFifoData == $past(rxChar))
	else $error("fifo data differs from character");
special_when_en_a: assert property (specialCharSeen |-> $past(rxCharValid && cfgReg[6]))
	else $error("special character flagged while off");
halt_needs_pause_a: assert property ($rose(txHalt) |-> $past(rxCharValid && cfgReg[0] && cfgReg[4:3] != 2'b00))
	else $error("transmitter halted without pause");
flow_off_release_a: assert property (!cfgReg[0] ##1 !cfgReg[0] |-> !txHalt)
	else $error("halt held with flow control off");
read_pulse_only_a: assert property (regRdData != 32'h0 |-> $past(regRead))
	else $error("read data without read strobe");
pause_req_cause_a: assert property (sendPauseReq |-> $past(rxFifoAlmostFull && cfgReg[0] && cfgReg[2:1] != 2'b00))
	else $error("pause request without cause");
resume_req_cause_a: assert property (sendResumeReq |-> $past(!rxFifoAlmostFull && cfgReg[0]))
	else $error("resume request without cause");
endmodule // usfdc_flow_ctrl_asserts
bind usfdc_flow_ctrl usfdc_flow_ctrl_asserts #(.CHAR_W(CHAR_W)) chk (.*);

// ===== usfdc_flow_ctrl_tb.sv
/*
 self-checking bench of the flow control block with a serial peer.
 assumes the peer model and the checker are compiled before it.
*/
`timescale 1ns/10ps
module usfdc_flow_ctrl_tb;
reg clock = 0, rst = 1, regWrite = 0, regRead = 0, rawRx = 0, rawTx = 0, errIrq = 0;
reg go = 0, almostFull = 0;
reg [7:0] regAddr = 8'h00, ch = 8'h00, c;
reg [31:0] regWrData = 32'h0, seed = 32'hd9f1, d;
wire [31:0] rdData;
wire rxDmaReq, txDmaReq, rxCharValid, fifoWr, special, txHalt, pauseReq, resumeReq;
wire [7:0] rxChar, fifoData, flowChar;
integer n_fail = 0, n_tests = 0, i, m;
usfdc_flow_ctrl usfdc_flow_ctrl_inst (.clock(clock), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(rdData),
	.rxDmaReqRaw(rawRx), .txDmaReqRaw(rawTx), .uartErrIrq(errIrq), .rxDmaReq(rxDmaReq),
	.txDmaReq(txDmaReq), .rxChar(rxChar), .rxCharValid(rxCharValid), .rxFifoData(fifoData),
	.rxFifoWrite(fifoWr), .specialCharSeen(special), .txHalt(txHalt),
	.rxFifoAlmostFull(almostFull), .sendPauseReq(pauseReq), .sendResumeReq(resumeReq),
	.flowCharOut(flowChar));
usfdc_peer_model usfdc_peer_model_inst (.clock(clock), .rst(rst), .go(go), .ch(ch),
	.rxChar(rxChar), .rxCharValid(rxCharValid));
// ----------------------------------------
// helpers
// ----------------------------------------
initial begin
	forever #5 clock = ~clock;
end
function [31:0] lfsr(input [31:0] x);
	lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
function [7:0] pz(input integer md);
	pz = (md == 2) ? 8'h93 : 8'h13;
endfunction
function [7:0] rs(input integer md);
	rs = (md == 2) ? 8'h91 : 8'h11;
endfunction
task chk(input [31:0] exp, input [31:0] got, input string nm);
	n_tests++;
	if (got !== exp) begin
		n_fail++;
		$display("wrong value %s expected %h seen %h", nm, exp, got);
	end
endtask
task wr(input [7:0] a, input [31:0] v);
	@(posedge clock);
	regWrite <= 1'b1; regAddr <= a; regWrData <= v;
	@(posedge clock);
	regWrite <= 1'b0;
endtask
task rd(input [7:0] a);
	@(posedge clock);
	regRead <= 1'b1; regAddr <= a;
	@(posedge clock);
	regRead <= 1'b0;
	#1 d = rdData;
endtask
task sendc(input [7:0] v);
	@(posedge clock);
	go <= 1'b1; ch <= v;
	@(posedge clock);
	go <= 1'b0;
	@(posedge clock);
	#1;
endtask
task stop_test;
	if (n_fail == 0 && n_tests > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
initial begin
	repeat (3) @(posedge clock);
	rst <= 1'b0;
	for (i = 0; i < 8; i++) begin rd(8'h48 + 4 * i); chk(0, d, "reset"); end
	for (i = 0; i < 4; i++) begin
		seed = lfsr(seed);
		wr(8'h54 + 4 * i, {24'h0, seed[7:0]});
		rd(8'h54 + 4 * i); chk(seed[7:0], d, "char");
	end
	wr(8'h70, seed); rd(8'h70); chk(0, d, "unmapped");
	for (i = 0; i < 64; i++) begin
		seed = lfsr(seed);
		wr(8'h48, {28'h0, seed[3], 1'b0, seed[1:0]});
		@(posedge clock);
		rawRx <= seed[4]; rawTx <= seed[5]; errIrq <= seed[6];
		#1 chk(seed[4] & seed[0] & ~(seed[3] & seed[6]), rxDmaReq, "rxdma");
		chk(seed[5] & seed[1], txDmaReq, "txdma");
	end
	wr(8'h54, 8'h11); wr(8'h58, 8'h91); wr(8'h5c, 8'h13); wr(8'h60, 8'h93);
	for (m = 1; m < 4; m++) begin
		wr(8'h50, (m << 3) | 1);
		sendc(pz(m)); chk(1, txHalt, "halt"); chk(0, fifoWr, "pausefifo");
		seed = lfsr(seed); c = {seed[7:1], 1'b0};
		sendc(c); chk(1, txHalt, "hold"); chk(c, fifoData, "fdata");
		sendc(rs(m)); chk(0, txHalt, "resume");
		sendc(pz(m ^ 3)); chk(m == 3, txHalt, "pair");
	end
	sendc(8'h11);
	wr(8'h50, 8'h29); sendc(8'h13); chk(1, txHalt, "anyhalt");
	sendc(c); chk(0, txHalt, "anyresume");
	wr(8'h50, 8'h08); sendc(8'h13); chk(0, txHalt, "off"); chk(1, fifoWr, "offfifo");
	for (m = 0; m < 4; m++) begin
		wr(8'h50, (m << 1) | 1);
		@(posedge clock) almostFull <= 1'b1;
		@(posedge clock) #1 chk(m != 0, pauseReq, "pausereq");
		if (m != 0) chk(pz(m), flowChar, "pausechar");
		@(posedge clock) almostFull <= 1'b0;
		@(posedge clock) #1 chk(m != 0, resumeReq, "resumereq");
		if (m != 0) chk(rs(m), flowChar, "resumechar");
	end
	wr(8'h50, 8'h03); sendc(8'h11); chk(0, special, "specoff");
	wr(8'h50, 8'h43); sendc(8'h11); chk(1, special, "specon");
	stop_test;
end
initial begin
	repeat (20000) @(posedge clock);
	n_fail++;
	stop_test;
end
endmodule // usfdc_flow_ctrl_tb

// ===== usfdc_peer_model.sv
/*
 serial peer: hands received characters to the block one cycle after a request.
 assumes the bench raises go for one cycle per character.
*/
`timescale 1ns/10ps
module usfdc_peer_model (
	input clock,
	input rst,
	input go,
	input [7:0] ch,
	output reg [7:0] rxChar,
	output reg rxCharValid
);
// between characters the line inverts its last value every cycle
always @(posedge clock or posedge rst) begin
	if (rst) begin
		rxCharValid <= 1'b0;
		rxChar <= 8'h00;
	end else begin
		rxCharValid <= go;
		rxChar <= go ? ch : ~rxChar;
	end
end
endmodule // usfdc_peer_model
